// >>> hdl/dsc_defines.svh
// offsets, field positions, reset values and timing counts of the serial config port
// assumes: included by bare name from the package and from the bench; both ends get it through the package
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// device register offsets (13-bit address space, five bits in short form)
`define DSC_OFF_CTL      13'h0000
`define DSC_OFF_DATAPATH 13'h0002
`define DSC_OFF_REV      13'h000d
`define DSC_OFF_CALSEL   13'h000e
`define DSC_OFF_CALCMD   13'h000f
`define DSC_OFF_CALADDR  13'h0010
`define DSC_OFF_CALDATA  13'h0011

// reset values
`define DSC_RST_CTL      8'h80
`define DSC_RST_DATAPATH 8'h00
`define DSC_RST_CALSEL   8'h00
`define DSC_RST_CALCMD   8'h00
`define DSC_RST_CALADDR  8'h00
`define DSC_RST_CALDATA  8'h3f

// writable bits of each masked register; control is written whole
`define DSC_WM_DATAPATH  8'h9d
`define DSC_WM_CALSEL    8'h37
`define DSC_WM_CALCMD    8'h4d
`define DSC_WM_CALADDR   8'h3f
`define DSC_WM_CALDATA   8'h3f

// serial_port_control fields and the cal command status bit
`define DSC_CTL_WIRE     7
`define DSC_CTL_ORDER    6
`define DSC_CTL_SOFT     5
`define DSC_CTL_LONG     4
`define DSC_CALCMD_STAT  7

// instruction lengths in bits
`define DSC_INST_SHORT   5'd8
`define DSC_INST_LONG    5'd16

// timing
`define DSC_CLK_NS        20
`define DSC_SCLK_MIN_NS   50
`define DSC_SCLK_HALF_NS  160
`define DSC_SCLK_HALF_CYC ((`DSC_SCLK_HALF_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_SETTLE_NS     1000
`define DSC_SETTLE_CYC    ((`DSC_SETTLE_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)

// host command port registers and control fields
`define DSC_H_CTRL   3'h0
`define DSC_H_INSTR  3'h1
`define DSC_H_TXD    3'h2
`define DSC_H_RXD    3'h3
`define DSC_H_STAT   3'h4
`define DSC_HC_START 0
`define DSC_HC_LSB   1
`define DSC_HC_FOUR  2
`define DSC_HC_LONG  3
`define DSC_HC_STRAP 4
`define DSC_HC_PSCLK 5
`define DSC_HC_PSDIO 6
`define DSC_HC_PSEL  7

`endif

// >>> hdl/dsc_pkg.sv
// types shared by both ends of the serial config port
// assumes: dsc_defines.svh on the include path
package dsc_pkg;
	`include "dsc_defines.svh"

	typedef enum logic [1:0] {
		DSC_D_INSTR = 2'b00,
		DSC_D_DATA  = 2'b01,
		DSC_D_DONE  = 2'b10
	} dsc_dev_state_t;

	typedef enum logic [2:0] {
		DSC_H_IDLE  = 3'b000,
		DSC_H_SETUP = 3'b001,
		DSC_H_LOW   = 3'b010,
		DSC_H_HIGH  = 3'b011,
		DSC_H_END   = 3'b100
	} dsc_host_state_t;

	// device state; pin vectors are {strap, sdio, select_n, sclk}
	typedef struct packed {
		logic [3:0]     s1;
		logic [3:0]     s2;
		logic [3:0]     s3;
		logic [3:0]     f;
		dsc_dev_state_t state;
		logic [15:0]    sh;
		logic [4:0]     bit_cnt;
		logic           rd;
		logic [1:0]     left;
		logic [12:0]    addr;
		logic [7:0]     out_sh;
		logic           sdio_o;
		logic           sdio_oe_n;
		logic           sdo_o;
		logic           sdo_oe_n;
		logic [7:0]     ctl;
		logic [7:0]     dpath;
		logic [7:0]     calsel;
		logic [7:0]     calcmd;
		logic [7:0]     caladdr;
		logic [7:0]     caldata;
		logic           pin_mode;
		logic           pin_clk;
		logic           pin_fmt;
		logic           pin_pdn;
	} dsc_dev_st_t;

	// host state; pin vectors are {sdo, sdio}
	typedef struct packed {
		logic [1:0]      s1;
		logic [1:0]      s2;
		logic [1:0]      s3;
		logic [1:0]      f;
		dsc_host_state_t state;
		logic [3:0]      div;
		logic [5:0]      bit_cnt;
		logic [5:0]      total;
		logic [4:0]      ibits;
		logic [47:0]     tx;
		logic [31:0]     rx;
		logic [31:0]     txd;
		logic [31:0]     rdata;
		logic [15:0]     instr;
		logic [7:0]      cfg;
		logic            rd;
		logic            busy;
		logic            sclk;
		logic            sel_n;
		logic            strap;
		logic            sdio_o;
		logic            sdio_oe_n;
		logic [5:0]      settle;
	} dsc_host_st_t;
endpackage

// >>> hdl/dsc_if.sv
// link between the serial config host and the device port
// assumes: the bench instantiates it and resolves nothing else; undriven lines pull high
`timescale 1ns/1ps
interface dsc_if;
	logic sclk;
	logic select_n;
	logic port_reset;
	logic host_sdio_o;
	logic host_sdio_oe_n;
	logic dev_sdio_o;
	logic dev_sdio_oe_n;
	logic dev_sdo_o;
	logic dev_sdo_oe_n;
	logic sdio;
	logic sdo;

	// wire level of the shared data line, pulled high when nobody drives
	assign sdio = !dev_sdio_oe_n ? dev_sdio_o : (!host_sdio_oe_n ? host_sdio_o : 1'b1);
	assign sdo  = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;

	modport device (
		input  sclk, select_n, port_reset, sdio,
		output dev_sdio_o, dev_sdio_oe_n, dev_sdo_o, dev_sdo_oe_n
	);
	modport host (
		output sclk, select_n, port_reset, host_sdio_o, host_sdio_oe_n,
		input  sdio, sdo
	);
endinterface

// >>> hdl/dsc_dev.sv
// device end of the serial config port: instruction decode, register file, pin mode
// assumes: link pins come from another domain and are sampled on core_clk_i
//
// Contract
// - instruction byte first, then the data phase
// - instruction bit 7 set means read
// - bits 6:5 give one to four bytes
// - bits 4:0 give the start address
// - strap high then low restarts instruction
// - port reset drops partial byte, no write
// - register written at each byte's last bit
// - sample on rising, launch on falling edge
// - host keeps serial clock at most 20 MHz
// - data pin released while select high
// - host holds select low whole cycle
// - order bit picks MSB or LSB first
// - MSB first steps address downward
// - LSB first steps address upward
// - host sends MSB-first bytes high address first
// - wire mode applies from next bit on
// - soft reset restores all but control register
// - host uses single bytes for config changes
// - strap high turns pins into static controls
// - host waits one microsecond after format change
// - wire mode: zero four-wire, one three-wire
// - soft reset bit clears itself when done
// - long instruction gives thirteen address bits
`timescale 1ns/1ps
module dsc_dev
	import dsc_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h05 // arbitrary identity value
) (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	dsc_if.device           link,
	input  wire logic       cal_done_i,
	output logic [7:0]      ctl_o,
	output logic [7:0]      datapath_o,
	output logic [7:0]      cal_select_o,
	output logic [7:0]      cal_command_o,
	output logic [7:0]      cal_address_o,
	output logic [7:0]      cal_data_o,
	output logic            pin_mode_o,
	output logic            clock_mode_strap_o,
	output logic            data_format_pin_o,
	output logic            power_down_pin_o
);

	dsc_dev_st_t r_reg;
	dsc_dev_st_t r_next;
	logic [15:0] word;
	logic        rise;
	logic        fall;
	logic        lsb;
	logic        obit;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// shift one serial bit into the assembly register
	function automatic logic [15:0] dsc_shift(input logic [15:0] sh, input logic b,
		input logic lsb_first);
		dsc_shift = lsb_first ? {b, sh[15:1]} : {sh[14:0], b};
	endfunction

	// right-align the received unit whatever the bit order
	function automatic logic [15:0] dsc_word(input logic [15:0] sh, input logic lsb_first,
		input logic lng);
		if (lng)
			dsc_word = sh;
		else if (lsb_first)
			dsc_word = {8'h00, sh[15:8]};
		else
			dsc_word = {8'h00, sh[7:0]};
	endfunction

	// register read decode; unmapped addresses read zero
	function automatic logic [7:0] dsc_read(input dsc_dev_st_t s, input logic [12:0] a,
		input logic done);
		case (a)
			`DSC_OFF_CTL:      dsc_read = s.ctl;
			`DSC_OFF_DATAPATH: dsc_read = s.dpath;
			`DSC_OFF_REV:      dsc_read = REVISION;
			`DSC_OFF_CALSEL:   dsc_read = s.calsel;
			`DSC_OFF_CALCMD:   dsc_read = {done, s.calcmd[6:0]};
			`DSC_OFF_CALADDR:  dsc_read = s.caladdr;
			`DSC_OFF_CALDATA:  dsc_read = s.caldata;
			default:           dsc_read = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		r_next = r_reg;
		word   = 16'h0000;
		obit   = 1'b0;
		// three-stage sampling; a level is accepted once stages two and three agree
		r_next.s1 = {link.port_reset, link.sdio, link.select_n, link.sclk};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		for (int i = 0; i < 4; i++) begin
			if (r_reg.s2[i] == r_reg.s3[i])
				r_next.f[i] = r_reg.s3[i];
		end
		rise = !r_reg.f[0] && r_next.f[0];
		fall = r_reg.f[0] && !r_next.f[0];
		lsb  = r_reg.ctl[`DSC_CTL_ORDER];

		// soft reset completes one cycle after it is written, then clears itself
		if (r_reg.ctl[`DSC_CTL_SOFT]) begin
			r_next.dpath   = `DSC_RST_DATAPATH;
			r_next.calsel  = `DSC_RST_CALSEL;
			r_next.calcmd  = `DSC_RST_CALCMD;
			r_next.caladdr = `DSC_RST_CALADDR;
			r_next.caldata = `DSC_RST_CALDATA;
			r_next.ctl[`DSC_CTL_SOFT] = 1'b0;
		end

		r_next.pin_mode = r_next.f[3];
		if (r_next.f[3] || r_next.f[1]) begin
			// strap high or select high: back to the instruction phase, nothing written
			r_next.state     = DSC_D_INSTR;
			r_next.bit_cnt   = 5'd0;
			r_next.sdio_oe_n = 1'b1;
			r_next.sdo_oe_n  = 1'b1;
			if (r_next.f[3]) begin
				// pins followed continuously, not latched
				r_next.pin_clk = r_next.f[0];
				r_next.pin_fmt = r_next.f[2];
				r_next.pin_pdn = r_next.f[1];
			end
		end else if (rise) begin
			case (r_reg.state)
				DSC_D_INSTR: begin
					r_next.sh      = dsc_shift(r_reg.sh, r_next.f[2], lsb);
					r_next.bit_cnt = 5'(r_reg.bit_cnt + 5'd1);
					if (r_next.bit_cnt == (r_reg.ctl[`DSC_CTL_LONG] ? `DSC_INST_LONG
						: `DSC_INST_SHORT)) begin
						word = dsc_word(r_next.sh, lsb, r_reg.ctl[`DSC_CTL_LONG]);
						if (r_reg.ctl[`DSC_CTL_LONG]) begin
							r_next.rd   = word[15];
							r_next.left = word[14:13];
							r_next.addr = word[12:0];
						end else begin
							r_next.rd   = word[7];
							r_next.left = word[6:5];
							r_next.addr = {8'h00, word[4:0]};
						end
						r_next.bit_cnt = 5'd0;
						r_next.state   = DSC_D_DATA;
						r_next.out_sh  = dsc_read(r_reg, r_next.addr, cal_done_i);
					end
				end
				DSC_D_DATA: begin
					r_next.sh      = dsc_shift(r_reg.sh, r_next.f[2], lsb);
					r_next.bit_cnt = 5'(r_reg.bit_cnt + 5'd1);
					if (r_next.bit_cnt == 5'd8) begin
						word = dsc_word(r_next.sh, lsb, 1'b0);
						// write lands on the byte's last edge, not at cycle end
						if (!r_reg.rd) begin
							case (r_reg.addr)
								`DSC_OFF_CTL:      r_next.ctl = word[7:0];
								`DSC_OFF_DATAPATH: r_next.dpath = word[7:0] & `DSC_WM_DATAPATH;
								`DSC_OFF_CALSEL:   r_next.calsel = word[7:0] & `DSC_WM_CALSEL;
								`DSC_OFF_CALCMD:   r_next.calcmd = word[7:0] & `DSC_WM_CALCMD;
								`DSC_OFF_CALADDR:  r_next.caladdr = word[7:0] & `DSC_WM_CALADDR;
								`DSC_OFF_CALDATA:  r_next.caldata = word[7:0] & `DSC_WM_CALDATA;
								default: ;
							endcase
						end
						// step with the order just written, so a new setting applies at once
						if (r_next.ctl[`DSC_CTL_ORDER])
							r_next.addr = 13'(r_reg.addr + 13'd1);
						else
							r_next.addr = 13'(r_reg.addr - 13'd1);
						r_next.bit_cnt = 5'd0;
						r_next.left    = 2'(r_reg.left - 2'd1);
						if (r_reg.left == 2'd0)
							r_next.state = DSC_D_DONE;
						else
							r_next.out_sh = dsc_read(r_next, r_next.addr, cal_done_i);
					end
				end
				DSC_D_DONE: ; // further edges ignored until select rises
				default: r_next.state = DSC_D_INSTR;
			endcase
		end else if (fall) begin
			if (r_reg.state == DSC_D_DATA && r_reg.rd) begin
				// launch one read bit per falling edge on the pin the wire mode picks
				obit          = r_next.ctl[`DSC_CTL_ORDER] ? r_reg.out_sh[0] : r_reg.out_sh[7];
				r_next.out_sh = r_next.ctl[`DSC_CTL_ORDER] ? {1'b0, r_reg.out_sh[7:1]}
					: {r_reg.out_sh[6:0], 1'b0};
				if (r_next.ctl[`DSC_CTL_WIRE]) begin
					r_next.sdio_o    = obit;
					r_next.sdio_oe_n = 1'b0;
					r_next.sdo_oe_n  = 1'b1;
				end else begin
					r_next.sdo_o     = obit;
					r_next.sdo_oe_n  = 1'b0;
					r_next.sdio_oe_n = 1'b1;
				end
			end else begin
				// the last bit stays until the falling edge after it
				r_next.sdio_oe_n = 1'b1;
				r_next.sdo_oe_n  = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register; select reset high so no false edge appears after reset
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			r_reg           <= '0;
			r_reg.s1        <= 4'h2;
			r_reg.s2        <= 4'h2;
			r_reg.s3        <= 4'h2;
			r_reg.f         <= 4'h2;
			r_reg.state     <= DSC_D_INSTR;
			r_reg.sdio_oe_n <= 1'b1;
			r_reg.sdo_oe_n  <= 1'b1;
			r_reg.ctl       <= `DSC_RST_CTL;
			r_reg.dpath     <= `DSC_RST_DATAPATH;
			r_reg.calsel    <= `DSC_RST_CALSEL;
			r_reg.calcmd    <= `DSC_RST_CALCMD;
			r_reg.caladdr   <= `DSC_RST_CALADDR;
			r_reg.caldata   <= `DSC_RST_CALDATA;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	assign link.dev_sdio_o    = r_reg.sdio_o;
	assign link.dev_sdio_oe_n = r_reg.sdio_oe_n;
	assign link.dev_sdo_o     = r_reg.sdo_o;
	assign link.dev_sdo_oe_n  = r_reg.sdo_oe_n;
	assign ctl_o              = r_reg.ctl;
	assign datapath_o         = r_reg.dpath;
	assign cal_select_o       = r_reg.calsel;
	assign cal_command_o      = r_reg.calcmd;
	assign cal_address_o      = r_reg.caladdr;
	assign cal_data_o         = r_reg.caldata;
	assign pin_mode_o         = r_reg.pin_mode;
	assign clock_mode_strap_o = r_reg.pin_clk;
	assign data_format_pin_o  = r_reg.pin_fmt;
	assign power_down_pin_o   = r_reg.pin_pdn;

endmodule

// >>> hdl/dsc_host.sv
// host end of the serial config port: command registers, serial clock divider, shifter
// assumes: software writes the command port; the device samples the link on its own clock
`timescale 1ns/1ps
module dsc_host
	import dsc_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        rst_i,
	dsc_if.host              link,
	input  wire logic [2:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o
);

	dsc_host_st_t r_reg;
	dsc_host_st_t r_next;
	logic         do_fall;
	logic         data_bit;
	logic [5:0]   j;

	// lay out instruction and data bytes in sending order, first bit at the top
	function automatic logic [47:0] dsc_stream(input logic [15:0] ins, input logic [31:0] d,
		input logic lsb_first, input logic lng);
		logic [47:0] s;
		logic [47:0] t;
		s = lng ? {ins, d[7:0], d[15:8], d[23:16], d[31:24]}
			: {ins[7:0], d[7:0], d[15:8], d[23:16], d[31:24], 8'h00};
		if (lsb_first && lng)
			s[47:32] = {ins[7:0], ins[15:8]};
		t = s;
		if (lsb_first) begin
			for (int k = 0; k < 48; k++)
				t[k] = s[(k / 8) * 8 + 7 - (k % 8)];
		end
		dsc_stream = t;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		r_next  = r_reg;
		do_fall = 1'b0;
		// returning data lines pass three stages
		r_next.s1 = {link.sdo, link.sdio};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		for (int i = 0; i < 2; i++) begin
			if (r_reg.s2[i] == r_reg.s3[i])
				r_next.f[i] = r_reg.s3[i];
		end
		// filtered level of this cycle: the registered copy lags the rising edge by one cycle
		data_bit = r_reg.cfg[`DSC_HC_FOUR] ? r_next.f[1] : r_next.f[0];
		j        = 6'(r_reg.bit_cnt - {1'b0, r_reg.ibits});
		if (r_reg.settle != 6'd0)
			r_next.settle = 6'(r_reg.settle - 6'd1);

		// command port writes
		if (wr_i) begin
			case (addr_i)
				`DSC_H_CTRL: begin
					r_next.cfg = {wdata_i[7:1], 1'b0};
					if (wdata_i[7:4] != r_reg.cfg[7:4])
						r_next.settle = 6'(`DSC_SETTLE_CYC);
				end
				`DSC_H_INSTR: r_next.instr = wdata_i[15:0];
				`DSC_H_TXD:   r_next.txd = wdata_i;
				default: ;
			endcase
		end
		// read data stands in the cycle after the strobe only
		r_next.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`DSC_H_CTRL:  r_next.rdata = {24'h00_0000, r_reg.cfg};
				`DSC_H_INSTR: r_next.rdata = {16'h0000, r_reg.instr};
				`DSC_H_TXD:   r_next.rdata = r_reg.txd;
				`DSC_H_RXD:   r_next.rdata = r_reg.rx;
				`DSC_H_STAT:  r_next.rdata = {30'h0, r_reg.settle == 6'd0, r_reg.busy};
				default:      r_next.rdata = 32'h0000_0000;
			endcase
		end

		case (r_reg.state)
			DSC_H_IDLE: begin
				// with the strap high the pins carry static levels
				r_next.strap     = r_next.cfg[`DSC_HC_STRAP];
				r_next.sclk      = r_next.strap && r_next.cfg[`DSC_HC_PSCLK];
				r_next.sel_n     = !r_next.strap || r_next.cfg[`DSC_HC_PSEL];
				r_next.sdio_o    = r_next.cfg[`DSC_HC_PSDIO];
				r_next.sdio_oe_n = !r_next.strap;
				if (wr_i && addr_i == `DSC_H_CTRL && wdata_i[`DSC_HC_START] && !r_next.strap) begin
					r_next.ibits   = r_next.cfg[`DSC_HC_LONG] ? `DSC_INST_LONG : `DSC_INST_SHORT;
					r_next.rd      = r_next.cfg[`DSC_HC_LONG] ? r_reg.instr[15] : r_reg.instr[7];
					r_next.total   = 6'(r_next.ibits) + {1'b0, (r_next.cfg[`DSC_HC_LONG]
						? r_reg.instr[14:13] : r_reg.instr[6:5]), 3'b000} + 6'd8;
					r_next.tx      = dsc_stream(r_reg.instr, r_reg.txd, r_next.cfg[`DSC_HC_LSB],
						r_next.cfg[`DSC_HC_LONG]);
					r_next.rx      = 32'h0000_0000;
					r_next.bit_cnt = 6'd0;
					r_next.sclk    = 1'b0;
					r_next.sel_n   = 1'b0;
					r_next.sdio_oe_n = 1'b1;
					r_next.div     = 4'(`DSC_SCLK_HALF_CYC - 1);
					r_next.busy    = 1'b1;
					r_next.state   = DSC_H_SETUP;
				end
			end
			DSC_H_SETUP: begin
				r_next.div = 4'(r_reg.div - 4'd1);
				if (r_reg.div == 4'd0)
					do_fall = 1'b1;
			end
			DSC_H_LOW: begin
				r_next.div = 4'(r_reg.div - 4'd1);
				if (r_reg.div == 4'd0) begin
					// half period well above the least the device accepts
					r_next.sclk    = 1'b1;
					r_next.bit_cnt = 6'(r_reg.bit_cnt + 6'd1);
					r_next.div     = 4'(`DSC_SCLK_HALF_CYC - 1);
					r_next.state   = DSC_H_HIGH;
					if (r_reg.rd && r_reg.bit_cnt >= {1'b0, r_reg.ibits})
						r_next.rx[{j[4:3], r_reg.cfg[`DSC_HC_LSB] ? j[2:0] : ~j[2:0]}] = data_bit;
				end
			end
			DSC_H_HIGH: begin
				r_next.div = 4'(r_reg.div - 4'd1);
				if (r_reg.div == 4'd0) begin
					if (r_reg.bit_cnt == r_reg.total) begin
						r_next.sclk  = 1'b0;
						r_next.div   = 4'(`DSC_SCLK_HALF_CYC - 1);
						r_next.state = DSC_H_END;
					end else begin
						do_fall = 1'b1;
					end
				end
			end
			DSC_H_END: begin
				r_next.div = 4'(r_reg.div - 4'd1);
				if (r_reg.div == 4'd0) begin
					r_next.sel_n     = 1'b1;
					r_next.sdio_oe_n = 1'b1;
					r_next.busy      = 1'b0;
					r_next.state     = DSC_H_IDLE;
				end
			end
			default: r_next.state = DSC_H_IDLE;
		endcase

		// falling edge: put out the next bit, or release the line in a read data phase
		if (do_fall) begin
			r_next.sclk  = 1'b0;
			r_next.div   = 4'(`DSC_SCLK_HALF_CYC - 1);
			r_next.state = DSC_H_LOW;
			if (r_reg.bit_cnt < {1'b0, r_reg.ibits} || !r_reg.rd) begin
				r_next.sdio_o    = r_reg.tx[47];
				r_next.sdio_oe_n = 1'b0;
				r_next.tx        = {r_reg.tx[46:0], 1'b0};
			end else begin
				r_next.sdio_oe_n = 1'b1;
			end
		end

		// strap raised mid-frame: drop the frame so the device sees a port reset at once
		if (r_next.cfg[`DSC_HC_STRAP] && r_reg.state != DSC_H_IDLE) begin
			r_next.strap     = 1'b1;
			r_next.sclk      = r_next.cfg[`DSC_HC_PSCLK];
			r_next.sel_n     = r_next.cfg[`DSC_HC_PSEL];
			r_next.sdio_oe_n = 1'b1;
			r_next.busy      = 1'b0;
			r_next.state     = DSC_H_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			r_reg           <= '0;
			r_reg.state     <= DSC_H_IDLE;
			r_reg.sel_n     <= 1'b1;
			r_reg.sdio_oe_n <= 1'b1;
			r_reg.s1        <= 2'h3;
			r_reg.s2        <= 2'h3;
			r_reg.s3        <= 2'h3;
			r_reg.f         <= 2'h3;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign link.sclk           = r_reg.sclk;
	assign link.select_n       = r_reg.sel_n;
	assign link.port_reset     = r_reg.strap;
	assign link.host_sdio_o    = r_reg.sdio_o;
	assign link.host_sdio_oe_n = r_reg.sdio_oe_n;
	assign rdata_o             = r_reg.rdata;

endmodule

// >>> tb/dsc_link_chk.sv
// timing and drive checks on the link between host and device ends
// assumes: instantiated beside the link interface, its signals fed in by name
`timescale 1ns/1ps
module dsc_link_chk (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic sclk,
	input  wire logic select_n,
	input  wire logic port_reset,
	input  wire logic dev_sdio_o,
	input  wire logic dev_sdio_oe_n,
	input  wire logic dev_sdo_oe_n
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	// release waits out the sync delay, so a bounded window is allowed
	sel_release_a: assert property ($rose(select_n) |->
		##[0:6] (dev_sdio_oe_n && dev_sdo_oe_n))
		else $error("data pins still driven after deselect");
	strap_release_a: assert property (port_reset [*8] |-> dev_sdio_oe_n && dev_sdo_oe_n)
		else $error("data pins driven while port strap high");
	launch_fall_a: assert property (!dev_sdio_oe_n && $past(!dev_sdio_oe_n)
		&& $changed(dev_sdio_o) |-> !sclk)
		else $error("read bit changed while serial clock high");
	one_pin_a: assert property (!(!dev_sdio_oe_n && !dev_sdo_oe_n))
		else $error("both read pins driven");
	drive_start_a: assert property ($fell(dev_sdio_oe_n) |->
		!select_n && !port_reset && !sclk)
		else $error("data pin driven outside a frame");
	idle_low_a: assert property (select_n |-> !sclk)
		else $error("serial clock high while deselected");
	high_width_a: assert property ($rose(sclk) |-> sclk [*8])
		else $error("serial clock high phase too short");
	low_width_a: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("serial clock low phase too short");
endmodule

// >>> tb/test_dac_serial_config_port.sv
// self-checking bench: host and device ends joined by the link interface
// assumes: design files compiled first, checker beside the link
`timescale 1ns/1ps
`include "dsc_defines.svh"
module test_dac_serial_config_port;
	import dsc_pkg::*;
	localparam logic [7:0] REV = 8'h05; // arbitrary identity value
	logic        core_clk_i = 1'b0;
	logic        rst_i      = 1'b1;
	logic [2:0]  addr_i     = 3'h0;
	logic [31:0] wdata_i    = 32'h0;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic        cal_done_i = 1'b0;
	logic [31:0] rdata_o;
	logic [7:0]  ctl_o, datapath_o, cal_select_o, cal_command_o, cal_address_o, cal_data_o;
	logic        pin_mode_o, clock_mode_strap_o, data_format_pin_o, power_down_pin_o;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles     = 0;
	logic [31:0] r, d;
	logic [7:0]  mdl [4] = '{8'h3f, 8'h00, 8'h00, 8'h00}; // 0x11 down to 0x0e
	logic [7:0]  msk [4] = '{8'h3f, 8'h3f, 8'h4d, 8'h37};
	logic [4:0]  ra [7]  = '{5'h00, 5'h02, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11};
	logic [7:0]  rv [7]  = '{8'h80, 8'h00, REV, 8'h00, 8'h00, 8'h00, 8'h3f};

	dsc_if link ();
	dsc_dev #(.REVISION(REV)) dsc_dev_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link),
		.cal_done_i(cal_done_i), .ctl_o(ctl_o), .datapath_o(datapath_o),
		.cal_select_o(cal_select_o), .cal_command_o(cal_command_o),
		.cal_address_o(cal_address_o), .cal_data_o(cal_data_o), .pin_mode_o(pin_mode_o),
		.clock_mode_strap_o(clock_mode_strap_o), .data_format_pin_o(data_format_pin_o),
		.power_down_pin_o(power_down_pin_o));
	dsc_host dsc_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	dsc_link_chk dsc_link_chk_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .sclk(link.sclk),
		.select_n(link.select_n), .port_reset(link.port_reset), .dev_sdio_o(link.dev_sdio_o),
		.dev_sdio_oe_n(link.dev_sdio_oe_n), .dev_sdo_oe_n(link.dev_sdo_oe_n));

	////////////////////////////////////////////////////////////////////////////////
	always #10 core_clk_i = ~core_clk_i;

	// hang guard: the whole run needs far fewer cycles
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] v);
		@(posedge core_clk_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 r = rdata_o;
	endtask

	task automatic wait_idle();
		for (int n = 0; n < 1000; n++) begin
			rd(`DSC_H_STAT);
			if (r[0] === 1'b0)
				break;
		end
	endtask

	// one frame; flg carries order and wire flags, start is added here
	task automatic cyc(input logic [7:0] ins, input logic [31:0] tx, input logic [7:0] flg);
		wr(`DSC_H_TXD, tx);
		wr(`DSC_H_INSTR, {24'h0, ins});
		wr(`DSC_H_CTRL, {24'h0, flg | 8'h01});
		wait_idle();
		rd(`DSC_H_RXD);
	endtask

	// expected read of c+1 bytes stepping down from 0x11
	function automatic logic [31:0] exp_rd(input int c);
		logic [31:0] v;
		v = 32'h0;
		for (int k = 0; k <= c; k++)
			v[8*k +: 8] = mdl[k];
		if (c >= 2)
			v[23] = c[0];
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(66));
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		// pin mode patterns, then strap low completes the port reset pulse
		for (int k = 0; k < 2; k++) begin
			d = k ? 32'h90 : 32'h70;
			wr(`DSC_H_CTRL, d);
			repeat (60) @(posedge core_clk_i);
			chk({pin_mode_o, clock_mode_strap_o, data_format_pin_o, power_down_pin_o},
				{1'b1, d[5], d[6], d[7]});
		end
		wr(`DSC_H_CTRL, 32'h0);
		repeat (60) @(posedge core_clk_i);
		// a microsecond has passed since the last strap change, so settled must show
		rd(`DSC_H_STAT);
		chk(r, 32'h2);
		for (int k = 0; k < 7; k++) begin
			cyc({3'b100, ra[k]}, 32'h0, 8'h00);
			chk(r, {24'h0, rv[k]});
		end
		// every byte count, MSB first, address stepping down from 0x11
		for (int c = 0; c < 4; c++) begin
			d = $urandom();
			cal_done_i <= c[0];
			cyc({1'b0, c[1:0], 5'h11}, d, 8'h00);
			for (int k = 0; k <= c; k++)
				mdl[k] = d[8*k +: 8] & msk[k];
			chk({cal_select_o, cal_command_o, cal_address_o, cal_data_o},
				{mdl[3], mdl[2], mdl[1], mdl[0]});
			cyc({1'b1, c[1:0], 5'h11}, 32'h0, 8'h00);
			chk(r, exp_rd(c));
		end
		// least significant bit first, address stepping up from 0x10
		cyc(8'h00, 32'hc0, 8'h00);
		chk(ctl_o, 8'hc0);
		d = $urandom();
		cyc({3'b001, 5'h10}, d, 8'h02);
		chk({cal_address_o, cal_data_o}, {d[7:0] & 8'h3f, d[15:8] & 8'h3f});
		mdl[1] = d[7:0] & 8'h3f;
		mdl[0] = d[15:8] & 8'h3f;
		cyc(8'h00, 32'h80, 8'h02);
		chk(ctl_o, 8'h80);
		// four-wire read on the separate pin
		cyc(8'h00, 32'h00, 8'h00);
		cyc({3'b100, 5'h11}, 32'h0, 8'h04);
		chk(r, {24'h0, mdl[0]});
		cyc(8'h00, 32'h80, 8'h00);
		// soft reset keeps the control register and clears itself
		d = $urandom();
		cyc({3'b000, 5'h02}, d, 8'h00);
		chk(datapath_o, d[7:0] & 8'h9d);
		cyc(8'h00, 32'ha0, 8'h00);
		chk({ctl_o, cal_command_o}, 16'h8000);
		chk({datapath_o, cal_select_o, cal_address_o, cal_data_o}, 32'h3f);
		// strap pulse in mid-frame drops the partial byte
		wr(`DSC_H_TXD, 32'h9d);
		wr(`DSC_H_INSTR, {27'h0, 5'h02});
		wr(`DSC_H_CTRL, 32'h01);
		repeat (200) @(posedge core_clk_i);
		wr(`DSC_H_CTRL, 32'h10);
		repeat (20) @(posedge core_clk_i);
		wr(`DSC_H_CTRL, 32'h00);
		wait_idle();
		chk(datapath_o, 8'h00);
		cyc({3'b000, 5'h02}, 32'h15, 8'h00);
		chk(datapath_o, 8'h15);
		end_sim();
	end
endmodule
